/* inc/trps_pkg.sv */
// Constants and types shared by the three-rail power sequencer
package trps_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_MHZ = 25;
	// Power-good hold-off after the primary supply becomes valid, in us
	localparam int GOOD_DELAY_US = 100;
	localparam int GOOD_DELAY_CYC = GOOD_DELAY_US * CLK_MHZ;
	// Core-on to io-on spacing in time-based mode, in us
	localparam int SEQ_DELAY_US = 20;
	localparam int SEQ_DELAY_CYC = SEQ_DELAY_US * CLK_MHZ;
	localparam int TMR_W = 12;

	// ----------------------------------------
	// Serial bus addressing and commands
	// ----------------------------------------
	localparam logic [3:0] SMB_ADDR_BASE = 4'hB;
	localparam logic [7:0] CMD_CTRL = 8'h00;
	localparam logic [7:0] CMD_STAT = 8'h01;

	// ----------------------------------------
	// Control byte fields (1 = force switch off)
	// ----------------------------------------
	localparam int CT_OFF_H = 0;
	localparam int CT_OFF_M = 1;
	localparam int CT_OFF_L = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;

	// ----------------------------------------
	// Status byte fields
	// ----------------------------------------
	localparam int ST_GATE_H = 0;
	localparam int ST_GATE_M = 1;
	localparam int ST_GATE_L = 2;
	localparam int ST_READY = 3;
	localparam int ST_OK_H = 4;
	localparam int ST_OK_M = 5;
	localparam int ST_OK_L = 6;
	localparam int ST_MODE_V = 7;

	// ----------------------------------------
	// State types
	// ----------------------------------------
	typedef enum logic [1:0] {SEQ_OFF, SEQ_CORE_ON, SEQ_ALL_ON, SEQ_IO_OFF} trps_seq_t;
	typedef enum logic [2:0] {SMB_IDLE, SMB_ADDR, SMB_ACK, SMB_WRITE, SMB_READ, SMB_RACK} trps_smb_t;

endpackage

/* inc/trps_tmr_if.sv */
// Handshake between the sequencer and its delay timers
`timescale 1ns/1ps
interface trps_tmr_if;
	logic ce;
	logic run;
	logic expired;
	modport ctl (output ce, output run, input expired);
	modport tmr (input ce, input run, output expired);
endinterface

/* core/trps_timer.sv */
// Delay timer: counts while run is high, flags when the limit is reached
`timescale 1ns/1ps
module trps_timer #(
	parameter int LIMIT = 1
) (
	input wire logic core_clk,
	input wire logic rst_n,
	trps_tmr_if.tmr t
);
	import trps_pkg::*;

	localparam logic [TMR_W-1:0] LIMIT_C = TMR_W'(LIMIT);

	logic [TMR_W-1:0] cnt_r;

	// Count up while running, restart whenever run drops
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else if (t.ce) begin
			if (!t.run)
				cnt_r <= '0;
			else if (cnt_r != LIMIT_C)
				cnt_r <= cnt_r + TMR_W'(1);
		end
	end

	assign t.expired = t.run && (cnt_r == LIMIT_C);
endmodule

/* core/trps_top.sv */
// Three-rail power sequencer control with serial bus status and switch-off
`timescale 1ns/1ps
// Function
// - Power-good low below lockout, then delayed release
// - Enable high and supply valid drive primary
// - Enable low holds primary switch off
// - Third-rail gate follows its pump enable
// - Second-rail gate follows its pump enable
// - Voltage mode: second rail waits feedback threshold
// - Voltage trigger starts voltage sequencing; tie unused
// - Timed trigger starts timed sequencing; tie unused
// - Rails coupled by comparator or timer
// - Core on first, core off last except on core lockout or host off, which drop both rails together
// - Separate lockout per supply; primary lockout also gates the linked rails
// - Host reads status, commands switches off
// - Three address pins select one of eight
// - Status bits mirror each switch drive
module trps_top (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic primary_supply_ok,
	input wire logic second_rail_supply_ok,
	input wire logic third_rail_supply_ok,
	input wire logic feedback_reached,
	input wire logic primary_switch_enable_in,
	input wire logic voltage_sequence_trigger,
	input wire logic timed_sequence_trigger,
	input wire logic bus_id_bit0,
	input wire logic bus_id_bit1,
	input wire logic bus_id_bit2,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	output logic ready_out,
	output logic ready_oe_n,
	output logic pump_h_en,
	output logic pump_m_en,
	output logic pump_l_en,
	output logic gate_h,
	output logic gate_m,
	output logic gate_l,
	output trps_pkg::trps_seq_t seq_state
);
	import trps_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	trps_tmr_if good_t ();
	trps_tmr_if seq_t ();

	trps_seq_t seq_r;
	trps_seq_t seq_nxt;
	trps_smb_t smb_r;
	logic mode_v_r;
	logic ready_r;
	logic gate_h_r;
	logic gate_m_r;
	logic gate_l_r;
	logic [2:0] ctrl_r;
	logic seq_req;
	logic link_on;
	logic off_h;
	logic off_m;
	logic off_l;
	logic scl_r;
	logic sda_r;
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic [7:0] shift_r;
	logic [2:0] bit_r;
	logic [7:0] cmd_r;
	logic byte_idx_r;
	logic rw_r;
	logic ack_on_r;
	logic nack_r;
	logic [7:0] rx_byte;
	logic [7:0] status_byte;
	logic [6:0] own_addr;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Shift one sampled bit into a byte
	function automatic logic [7:0] shift_in(input logic [7:0] b, input logic d);
		return {b[6:0], d};
	endfunction

	// ----------------------------------------
	// Timers
	// ----------------------------------------
	assign good_t.ce = clk_en;
	assign good_t.run = primary_supply_ok;
	assign seq_t.ce = clk_en;
	assign seq_t.run = (seq_r == SEQ_CORE_ON) || (seq_r == SEQ_IO_OFF);

	trps_timer #(.LIMIT(GOOD_DELAY_CYC)) u_good_tmr (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.t(good_t)
	);

	trps_timer #(.LIMIT(SEQ_DELAY_CYC)) u_seq_tmr (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.t(seq_t)
	);

	// ----------------------------------------
	// Power-good output
	// ----------------------------------------
	// Low below lockout, released after hold-off expires
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ready_r <= 1'b0;
		end else if (clk_en) begin
			ready_r <= primary_supply_ok && good_t.expired;
		end
	end

	assign ready_out = 1'b0;
	assign ready_oe_n = ready_r;

	// ----------------------------------------
	// Primary rail
	// ----------------------------------------
	assign off_h = ctrl_r[CT_OFF_H];
	assign off_m = ctrl_r[CT_OFF_M];
	assign off_l = ctrl_r[CT_OFF_L];

	// Primary pump follows enable pin, lockout and host off
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gate_h_r <= 1'b0;
		end else if (clk_en) begin
			gate_h_r <= primary_switch_enable_in && primary_supply_ok && !off_h;
		end
	end

	// ----------------------------------------
	// Secondary rail sequencing
	// ----------------------------------------
	assign seq_req = voltage_sequence_trigger || timed_sequence_trigger;
	assign link_on = seq_req && primary_supply_ok;

	// Core rail up first, io rail down first unless core lockout or host off drops both together
	always_comb begin
		seq_nxt = seq_r;
		unique case (seq_r)
			SEQ_OFF: begin
				if (link_on && third_rail_supply_ok && !off_l)
					seq_nxt = SEQ_CORE_ON;
			end
			SEQ_CORE_ON: begin
				if (!link_on || !third_rail_supply_ok || off_l)
					seq_nxt = SEQ_OFF;
				else if ((mode_v_r ? feedback_reached : seq_t.expired)
						&& second_rail_supply_ok && !off_m)
					seq_nxt = SEQ_ALL_ON;
			end
			SEQ_ALL_ON: begin
				if (!link_on || !third_rail_supply_ok || off_l)
					seq_nxt = SEQ_IO_OFF;
				else if (!second_rail_supply_ok || off_m)
					seq_nxt = SEQ_CORE_ON;
			end
			SEQ_IO_OFF: begin
				if (seq_t.expired)
					seq_nxt = SEQ_OFF;
			end
		endcase
	end

	// Sequencer state
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			seq_r <= SEQ_OFF;
		end else if (clk_en) begin
			seq_r <= seq_nxt;
		end
	end

	// Sequencing mode captured while idle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_v_r <= 1'b0;
		end else if (clk_en && seq_r == SEQ_OFF) begin
			mode_v_r <= voltage_sequence_trigger;
		end
	end

	// Secondary gate drives, each gated by its own lockout
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gate_m_r <= 1'b0;
			gate_l_r <= 1'b0;
		end else if (clk_en) begin
			gate_m_r <= (seq_nxt == SEQ_ALL_ON) && second_rail_supply_ok && !off_m;
			gate_l_r <= (seq_nxt != SEQ_OFF) && third_rail_supply_ok && !off_l;
		end
	end

	// Pumps and gates share one enable
	assign pump_h_en = gate_h_r;
	assign pump_m_en = gate_m_r;
	assign pump_l_en = gate_l_r;
	assign gate_h = gate_h_r;
	assign gate_m = gate_m_r;
	assign gate_l = gate_l_r;
	assign seq_state = seq_r;

	// ----------------------------------------
	// Serial bus line sampling
	// ----------------------------------------
	// Register lines and keep the previous sample for edges
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_r <= 1'b1;
			sda_r <= 1'b1;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (clk_en) begin
			scl_r <= scl_in;
			sda_r <= sda_in;
			scl_q <= scl_r;
			sda_q <= sda_r;
		end
	end

	assign scl_rise = scl_r && !scl_q;
	assign scl_fall = !scl_r && scl_q;
	assign bus_start = scl_r && scl_q && sda_q && !sda_r;
	assign bus_stop = scl_r && scl_q && !sda_q && sda_r;
	assign rx_byte = shift_in(shift_r, sda_r);
	assign own_addr = {SMB_ADDR_BASE, bus_id_bit2, bus_id_bit1, bus_id_bit0};

	// Status byte reflects the live switch drives
	always_comb begin
		status_byte = 8'h00;
		status_byte[ST_GATE_H] = gate_h_r;
		status_byte[ST_GATE_M] = gate_m_r;
		status_byte[ST_GATE_L] = gate_l_r;
		status_byte[ST_READY] = ready_r;
		status_byte[ST_OK_H] = primary_supply_ok;
		status_byte[ST_OK_M] = second_rail_supply_ok;
		status_byte[ST_OK_L] = third_rail_supply_ok;
		status_byte[ST_MODE_V] = mode_v_r;
	end

	// ----------------------------------------
	// Serial bus slave
	// ----------------------------------------
	// Address, command and data byte handling
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			smb_r <= SMB_IDLE;
			shift_r <= 8'h00;
			bit_r <= 3'h0;
			byte_idx_r <= 1'b0;
			rw_r <= 1'b0;
			ack_on_r <= 1'b0;
			nack_r <= 1'b0;
			cmd_r <= CMD_STAT;
		end else if (clk_en) begin
			if (bus_stop) begin
				smb_r <= SMB_IDLE;
				ack_on_r <= 1'b0;
			end else if (bus_start) begin
				smb_r <= SMB_ADDR;
				bit_r <= 3'h0;
				byte_idx_r <= 1'b0;
				ack_on_r <= 1'b0;
			end else begin
				unique case (smb_r)
					SMB_IDLE: begin
					end
					SMB_ADDR: begin
						if (scl_rise) begin
							shift_r <= rx_byte;
							bit_r <= bit_r + 3'h1;
							if (bit_r == 3'h7) begin
								rw_r <= sda_r;
								smb_r <= (shift_r[6:0] == own_addr) ? SMB_ACK : SMB_IDLE;
							end
						end
					end
					SMB_ACK: begin
						if (scl_fall) begin
							if (!ack_on_r) begin
								ack_on_r <= 1'b1;
							end else begin
								ack_on_r <= 1'b0;
								bit_r <= 3'h0;
								if (rw_r) begin
									shift_r <= status_byte;
									smb_r <= SMB_READ;
								end else begin
									smb_r <= SMB_WRITE;
								end
							end
						end
					end
					SMB_WRITE: begin
						if (scl_rise) begin
							shift_r <= rx_byte;
							bit_r <= bit_r + 3'h1;
							if (bit_r == 3'h7) begin
								byte_idx_r <= 1'b1;
								if (!byte_idx_r)
									cmd_r <= rx_byte;
								smb_r <= SMB_ACK;
							end
						end
					end
					SMB_READ: begin
						if (scl_fall) begin
							shift_r <= {shift_r[6:0], 1'b1};
							bit_r <= bit_r + 3'h1;
							if (bit_r == 3'h7)
								smb_r <= SMB_RACK;
						end
					end
					SMB_RACK: begin
						if (scl_rise)
							nack_r <= sda_r;
						if (scl_fall) begin
							bit_r <= 3'h0;
							if (nack_r) begin
								smb_r <= SMB_IDLE;
							end else begin
								shift_r <= status_byte;
								smb_r <= SMB_READ;
							end
						end
					end
					default: smb_r <= SMB_IDLE;
				endcase
			end
		end
	end

	// Host switch-off control byte
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= CTRL_RESET;
		end else if (clk_en && !bus_start && !bus_stop && smb_r == SMB_WRITE
				&& scl_rise && bit_r == 3'h7 && byte_idx_r && cmd_r == CMD_CTRL) begin
			ctrl_r <= rx_byte[2:0];
		end
	end

	// Open-drain data line: pull low for ack or a zero data bit
	assign sda_out = 1'b0;
	assign sda_oe_n = !(ack_on_r || (smb_r == SMB_READ && !shift_r[7]));
endmodule

/* testbench/trps_checker.sv */
// Port assertions for the power sequencer
`timescale 1ns/1ps
module trps_checker
	import trps_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic primary_supply_ok,
	input wire logic second_rail_supply_ok,
	input wire logic third_rail_supply_ok,
	input wire logic primary_switch_enable_in,
	input wire logic voltage_sequence_trigger,
	input wire logic timed_sequence_trigger,
	input wire logic ready_oe_n,
	input wire logic pump_h_en,
	input wire logic pump_m_en,
	input wire logic pump_l_en,
	input wire logic gate_h,
	input wire logic gate_m,
	input wire logic gate_l
);
	logic [15:0] ok_cnt_r;
	// Edges seen with the primary supply valid
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			ok_cnt_r <= 16'h0000;
		else if (!primary_supply_ok)
			ok_cnt_r <= 16'h0000;
		else if (ok_cnt_r != 16'hFFFF)
			ok_cnt_r <= ok_cnt_r + 16'h0001;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_prim_off: assert property (clk_en
		&& !(primary_switch_enable_in && primary_supply_ok) |=> !gate_h)
		else $error("primary gate on without enable");
	a_pump_gate: assert property (gate_h == pump_h_en && gate_m == pump_m_en && gate_l == pump_l_en)
		else $error("gate differs from pump");
	a_ready_low: assert property (!primary_supply_ok |=> !ready_oe_n)
		else $error("power good released in lockout");
	a_ready_delay: assert property ($rose(ready_oe_n) |-> ok_cnt_r > GOOD_DELAY_CYC)
		else $error("power good released early");
	a_core_first: assert property ($rose(gate_m) |-> gate_l)
		else $error("io rail before core");
	a_core_last: assert property ($fell(gate_l) |-> !gate_m || !$past(third_rail_supply_ok))
		else $error("core rail off before io");
	a_lock_m: assert property (!second_rail_supply_ok |=> !gate_m)
		else $error("io gate on in lockout");
	a_lock_l: assert property (!third_rail_supply_ok |=> !gate_l)
		else $error("core gate on in lockout");
	a_link_down: assert property (!voltage_sequence_trigger && !timed_sequence_trigger |=> !gate_m)
		else $error("io gate on without trigger");
	c_ready: cover property ($rose(ready_oe_n));
	c_io_on: cover property ($rose(gate_m));
	c_core_off: cover property ($fell(gate_l));
endmodule

/* testbench/trps_host.sv */
// Bus host model with pull-up on the data wire
`timescale 1ns/1ps
module trps_host (
	input wire logic core_clk,
	input wire logic sda_oe_n,
	output logic scl,
	output logic sda
);
	logic sda_m;
	// Wire is low if either party pulls it
	assign sda = sda_m & sda_oe_n;
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// One line phase lasting four clocks
	task automatic ph(input logic c, input logic d);
		@(posedge core_clk);
		scl <= c;
		sda_m <= d;
		repeat (3) @(posedge core_clk);
	endtask
	task automatic start();
		ph(1'b0, sda_m);
		ph(1'b0, 1'b1);
		ph(1'b1, 1'b1);
		ph(1'b1, 1'b0);
	endtask
	task automatic stop();
		ph(1'b0, sda_m);
		ph(1'b0, 1'b0);
		ph(1'b1, 1'b0);
		ph(1'b1, 1'b1);
	endtask
	// Nine bits MSB first, a one releases the wire
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			ph(1'b0, sda_m);
			ph(1'b0, tx[i]);
			ph(1'b1, tx[i]);
			rx[i] = sda;
		end
	endtask
endmodule

/* testbench/trps_tb_top.sv */
// Self-checking bench for the power sequencer
`timescale 1ns/1ps
module trps_tb_top;
	import trps_pkg::*;
	logic core_clk, rst_n, clk_en, primary_supply_ok, second_rail_supply_ok;
	logic third_rail_supply_ok, feedback_reached, primary_switch_enable_in;
	logic voltage_sequence_trigger, timed_sequence_trigger, scl_in, sda_in;
	logic bus_id_bit0, bus_id_bit1, bus_id_bit2, sda_out, sda_oe_n, ready_out;
	logic ready_oe_n, pump_h_en, pump_m_en, pump_l_en, gate_h, gate_m, gate_l;
	trps_seq_t seq_state;
	logic [2:0] id;
	logic [7:0] st;
	logic nk;
	int n_fail = 0;
	int checks = 0;
	int n;
	assign {bus_id_bit2, bus_id_bit1, bus_id_bit0} = id;
	trps_top dut (.*);
	trps_host h (.core_clk(core_clk), .sda_oe_n(sda_oe_n), .scl(scl_in), .sda(sda_in));
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
			n_fail++;
		end
	endtask
	task step(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	function automatic logic [15:0] gv();
		return {12'h000, ready_oe_n, gate_h, gate_m, gate_l};
	endfunction
	// Status with all supplies valid and power good
	function automatic logic [15:0] stat(input logic v, input logic [2:0] lmh);
		return {8'h00, v, 3'h7, 1'b1, lmh};
	endfunction
	task wr(input logic [2:0] a, input logic [7:0] d);
		logic [8:0] r;
		h.start();
		h.xfer({SMB_ADDR_BASE, a, 2'b01}, r);
		nk = r[0];
		h.xfer({CMD_CTRL, 1'b1}, r);
		h.xfer({d, 1'b1}, r);
		h.stop();
	endtask
	task rd();
		logic [8:0] r;
		h.start();
		h.xfer({SMB_ADDR_BASE, id, 2'b11}, r);
		h.xfer(9'h1FF, r);
		st = r[8:1];
		h.stop();
	endtask
	task end_of_test;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge core_clk);
		$display("watchdog expired");
		n_fail++;
		end_of_test();
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{clk_en, rst_n, primary_supply_ok, second_rail_supply_ok} = 4'h8;
		{third_rail_supply_ok, feedback_reached, primary_switch_enable_in} = 3'h0;
		{voltage_sequence_trigger, timed_sequence_trigger} = 2'h0;
		void'($urandom(93951));
		id = 3'($urandom);
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		step(1);
		chk(gv(), 16'h0000);
		chk({14'h0, sda_out, ready_out}, 16'h0000);
		for (int i = 0; i < 40; i++) begin
			@(posedge core_clk) {primary_switch_enable_in, primary_supply_ok} <= 2'($urandom);
			step(1);
			chk(16'(gate_h), 16'(primary_switch_enable_in & primary_supply_ok));
		end
		$display("done: primary");
		@(posedge core_clk) {primary_switch_enable_in, primary_supply_ok} <= 2'b10;
		@(posedge core_clk) primary_supply_ok <= 1'b1;
		n = 0;
		while (ready_oe_n !== 1'b1 && n < 3000) begin
			step(1);
			n++;
		end
		chk(16'(n), 16'(GOOD_DELAY_CYC + 1));
		@(posedge core_clk) primary_supply_ok <= 1'b0;
		step(1);
		chk(gv(), 16'h0000);
		@(posedge core_clk) {primary_supply_ok, second_rail_supply_ok, third_rail_supply_ok} <= 3'h7;
		step(GOOD_DELAY_CYC + 4);
		$display("done: power good");
		@(posedge core_clk) timed_sequence_trigger <= 1'b1;
		step(1);
		chk(gv(), 16'h000D);
		n = 0;
		while (gate_m !== 1'b1 && n < 1000) begin
			step(1);
			n++;
		end
		chk(16'(n), 16'(SEQ_DELAY_CYC + 1));
		chk(16'(seq_state), 16'(SEQ_ALL_ON));
		rd();
		chk(16'(st), stat(1'b0, 3'h7));
		@(posedge core_clk) timed_sequence_trigger <= 1'b0;
		step(1);
		chk(gv(), 16'h000D);
		chk(16'(seq_state), 16'(SEQ_IO_OFF));
		n = 0;
		while (gate_l !== 1'b0 && n < 1000) begin
			step(1);
			n++;
		end
		chk(16'(n), 16'(SEQ_DELAY_CYC + 1));
		chk(16'(seq_state), 16'(SEQ_OFF));
		$display("done: timed");
		@(posedge core_clk) timed_sequence_trigger <= 1'b1;
		step(SEQ_DELAY_CYC + 4);
		wr(id ^ 3'h1, 8'h07);
		step(2);
		chk({3'h0, nk, 12'h000} | gv(), 16'h100F);
		wr(id, 8'h02);
		step(2);
		chk({3'h0, nk, 12'h000} | gv(), 16'h000D);
		rd();
		chk(16'(st), stat(1'b0, 3'h5));
		chk({13'h0, pump_h_en, pump_m_en, pump_l_en}, 16'h0005);
		wr(id, 8'h05);
		step(2);
		chk(gv(), 16'h0008);
		wr(id, 8'h00);
		step(SEQ_DELAY_CYC + 4);
		chk(gv(), 16'h000F);
		@(posedge core_clk) timed_sequence_trigger <= 1'b0;
		step(SEQ_DELAY_CYC + 4);
		$display("done: bus");
		@(posedge core_clk) voltage_sequence_trigger <= 1'b1;
		step(50);
		chk(gv(), 16'h000D);
		@(posedge core_clk) feedback_reached <= 1'b1;
		step(1);
		chk(gv(), 16'h000F);
		rd();
		chk(16'(st), stat(1'b1, 3'h7));
		@(posedge core_clk) second_rail_supply_ok <= 1'b0;
		step(1);
		chk(gv(), 16'h000D);
		@(posedge core_clk) third_rail_supply_ok <= 1'b0;
		step(1);
		chk(gv(), 16'h000C);
		$display("done: voltage");
		// Enable low freezes the drives, then they catch up
		@(posedge core_clk) {clk_en, primary_switch_enable_in} <= 2'b00;
		step(3);
		chk(gv(), 16'h000C);
		@(posedge core_clk) clk_en <= 1'b1;
		step(1);
		chk(gv(), 16'h0008);
		$display("done: clock enable");
		end_of_test();
	end
endmodule
bind trps_top trps_checker chk_i (.*);
